// file: rtl/iso_fmt_pkg.sv
/*
  Constants shared by the isochronous packet formatter: register offsets,
  field positions, reset values and the code points of the packet fields.
  Assumes a 32-bit register port with byte addresses on word boundaries.
*/
package iso_fmt_pkg;

  // register map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] NODE_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] SID_OFF = 8'h0C;
  localparam logic [7:0] PORTS_LO_OFF = 8'h10;
  localparam logic [7:0] PORTS_HI_OFF = 8'h14;

  // control register fields
  localparam int CTRL_TX_AUTO_BIT = 0;
  localparam int CTRL_RX_AUTO_BIT = 1;
  localparam int CTRL_NODE_EMIT_BIT = 2;
  localparam logic CTRL_TX_AUTO_RESET = 1'b0;
  localparam logic CTRL_RX_AUTO_RESET = 1'b0;

  // node identity register fields
  localparam int NODE_ROOT_BIT = 16;
  localparam int NODE_BUS_LSB = 6;
  localparam logic [9:0] NODE_BUS_RESET = 10'h3FF;
  localparam logic [5:0] NODE_NUM_RESET = 6'h3F;

  // status register fields; writing a one clears the sticky flags
  localparam int STAT_ACK_BAD_BIT = 8;
  localparam int STAT_SPD_BAD_BIT = 9;

  // header and trailer quadlet layout
  localparam logic [3:0] TCODE_ISO = 4'hA;
  localparam int HDR_TCODE_LSB = 4;
  localparam int TRL_SPD_LSB = 16;
  localparam logic [15:0] SID_MARK_WORD = 16'h00E0;

  // speed codes
  localparam logic [1:0] SPD_100 = 2'b00;
  localparam logic [1:0] SPD_200 = 2'b01;
  localparam logic [1:0] SPD_400 = 2'b10;

  // acknowledge codes
  localparam logic [3:0] ACK_COMPLETE = 4'h1;
  localparam logic [3:0] ACK_PENDING = 4'h2;
  localparam logic [3:0] ACK_BUSY_X = 4'h4;
  localparam logic [3:0] ACK_BUSY_B = 4'h6;
  localparam logic [3:0] ACK_DATA_ERR = 4'hD;

  // self-identification fields
  localparam int SID_EXT_BIT = 23;
  localparam int SID_SEQ_LSB = 20;
  localparam int NUM_PORTS = 27;
  localparam int EXT_BASE_PORT = 3;
  localparam int EXT_PORTS_PER_PKT = 8;
  localparam int EXT_MAX_SEQ = 2;
  localparam logic [1:0] PS_PARENT = 2'b11;
  localparam logic [1:0] PS_CHILD = 2'b10;
  localparam logic [1:0] DEL_144NS = 2'b00;
  localparam logic [1:0] SP_RESERVED = 2'b11;

  typedef enum logic [1:0] {
    RXK_HEADER = 2'b00,
    RXK_PAYLOAD = 2'b01,
    RXK_TRAILER = 2'b10
  } rx_kind_t;

  typedef enum logic [1:0] {
    SIDK_START = 2'b00,
    SIDK_PACKET = 2'b01,
    SIDK_END = 2'b10
  } sid_kind_t;

  typedef enum logic [1:0] {
    O_IDLE = 2'b00,
    O_HI = 2'b01,
    O_LO = 2'b10,
    O_EXTRA = 2'b11
  } out_state_t;

  function automatic logic ack_known(input logic [3:0] ack);
    ack_known = (ack == ACK_COMPLETE) || (ack == ACK_PENDING) ||
                (ack >= ACK_BUSY_X && ack <= ACK_BUSY_B) ||
                (ack >= ACK_DATA_ERR);
  endfunction

endpackage

// file: rtl/iso_bus_packet_formatter.sv
/*
  Isochronous packet formatter: pairs port words into transmit buffer
  quadlets, splits received, snooped, node-identity and self-id quadlets
  into port words, and fills the receive and async receive buffers.
  Assumes link-core sources and buffers on CORE_CLK, with valid/ready.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module iso_bus_packet_formatter import iso_fmt_pkg::*; (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WSTB,
  input wire logic RSTB,
  output logic [31:0] RDATA,
  // received isochronous packets from the link core
  input wire logic RX_VALID,
  input wire logic [1:0] RX_KIND,
  input wire logic [31:0] RX_DATA,
  input wire logic [1:0] RX_SPD,
  input wire logic [3:0] RX_ACK,
  output logic RX_READY,
  // iso receive buffer write side
  output logic IRB_WE,
  output logic [31:0] IRB_DATA,
  // snooped packets
  input wire logic SNP_VALID,
  input wire logic [31:0] SNP_DATA,
  input wire logic SNP_IS_ACK,
  input wire logic [1:0] SNP_SPD,
  output logic SNP_READY,
  // self-identification stream
  input wire logic SID_VALID,
  input wire logic [1:0] SID_KIND,
  input wire logic [31:0] SID_DATA,
  input wire logic [3:0] SID_ACK,
  output logic SID_READY,
  // async receive buffer write side
  output logic ARB_WE,
  output logic [31:0] ARB_DATA,
  // iso parallel port, device to far side
  output logic [15:0] ISO_OUT_WORD,
  output logic ISO_OUT_VALID,
  input wire logic ISO_OUT_READY,
  // iso parallel port, far side to device
  input wire logic [15:0] ISO_IN_WORD,
  input wire logic ISO_IN_VALID,
  input wire logic ISO_IN_LAST,
  output logic ISO_IN_READY,
  // iso transmit buffer write side
  output logic ITB_WE,
  output logic [31:0] ITB_DATA,
  output logic ITB_HDR,
  input wire logic ITB_FULL
);

  logic tx_auto_reg, rx_auto_reg, node_emit_reg;
  logic root_reg;
  logic [9:0] bus_num_reg;
  logic [5:0] node_num_reg;
  logic [3:0] last_ack_reg;
  logic ack_bad_reg, spd_bad_reg;
  logic [31:0] sid0_reg;
  logic [2*NUM_PORTS-1:0] port_stat_reg;
  out_state_t out_state_reg;
  logic [31:0] quad_reg;
  logic [15:0] word_reg, extra_reg;
  logic inv_pend_reg, extra_pend_reg;
  logic [15:0] tx_hi_reg;
  logic tx_have_hi_reg, tx_first_reg;

  logic idle, rx_port, rx_take, sid_take, snp_take, node_take, load;
  logic load_inv, load_extra;
  logic [31:0] load_quad, hdr_fixed;
  logic in_take, out_step;
  logic parent_found, manager_capable, delay_ok, bus_powered;

  // tcode forced whatever the link core delivered
  assign hdr_fixed = {RX_DATA[31:8], TCODE_ISO, RX_DATA[3:0]};

  // arbitration: self-id, then receive, then snoop, then node identity
  assign idle = (out_state_reg == O_IDLE);
  assign rx_port = (RX_KIND == RXK_PAYLOAD) ||
                   (RX_KIND == RXK_HEADER && !rx_auto_reg);
  assign sid_take = SID_VALID && idle;
  assign rx_take = RX_VALID && (!rx_port || (idle && !SID_VALID));
  assign snp_take = SNP_VALID && idle && !SID_VALID &&
                    !(RX_VALID && rx_port);
  assign node_take = node_emit_reg && idle && !SID_VALID &&
                     !(RX_VALID && rx_port) && !SNP_VALID;
  assign load = sid_take || (rx_take && rx_port) || snp_take || node_take;
  assign load_inv = sid_take && (SID_KIND == SIDK_PACKET);
  assign load_extra = snp_take && SNP_IS_ACK;
  assign SID_READY = idle;
  assign RX_READY = !rx_port || (idle && !SID_VALID);
  assign SNP_READY = idle && !SID_VALID && !(RX_VALID && rx_port);
  assign ISO_OUT_VALID = (out_state_reg != O_IDLE);
  assign ISO_OUT_WORD = word_reg;
  assign out_step = ISO_OUT_VALID && ISO_OUT_READY;

  always_comb begin
    load_quad = 32'h0000_0000;
    if (sid_take) begin
      case (SID_KIND)
        SIDK_START: load_quad = {16'h0000, SID_MARK_WORD};
        SIDK_PACKET: load_quad = SID_DATA;
        default: load_quad = {28'h000_0000, SID_ACK};
      endcase
    end else if (rx_take && rx_port) begin
      load_quad = (RX_KIND == RXK_HEADER) ? hdr_fixed : RX_DATA;
    end else if (snp_take) begin
      load_quad = SNP_DATA;
    end else if (node_take) begin
      load_quad = {root_reg, 15'h0000, bus_num_reg, node_num_reg};
    end
  end

  // word sequencer: upper half, lower half, optional inverse or extra
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      out_state_reg <= O_IDLE;
      quad_reg <= 32'h0000_0000;
      word_reg <= 16'h0000;
      extra_reg <= 16'h0000;
      inv_pend_reg <= 1'b0;
      extra_pend_reg <= 1'b0;
    end else begin
      case (out_state_reg)
        O_IDLE: begin
          if (load) begin
            quad_reg <= load_quad;
            word_reg <= load_quad[31:16];
            inv_pend_reg <= load_inv;
            extra_pend_reg <= load_extra;
            extra_reg <= {14'h0000, SNP_SPD};
            out_state_reg <= O_HI;
          end
        end
        O_HI: begin
          if (ISO_OUT_READY) begin
            word_reg <= quad_reg[15:0];
            out_state_reg <= O_LO;
          end
        end
        O_LO: begin
          if (ISO_OUT_READY) begin
            if (inv_pend_reg) begin
              quad_reg <= ~quad_reg;
              word_reg <= ~quad_reg[31:16];
              inv_pend_reg <= 1'b0;
              out_state_reg <= O_HI;
            end else if (extra_pend_reg) begin
              word_reg <= extra_reg;
              extra_pend_reg <= 1'b0;
              out_state_reg <= O_EXTRA;
            end else begin
              out_state_reg <= O_IDLE;
            end
          end
        end
        O_EXTRA: begin
          if (ISO_OUT_READY) begin
            out_state_reg <= O_IDLE;
          end
        end
        default: out_state_reg <= O_IDLE;
      endcase
    end
  end

  // async receive buffer: zero, quadlet, inverse, ..., zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ARB_WE <= 1'b0;
      ARB_DATA <= 32'h0000_0000;
    end else if (sid_take) begin
      ARB_WE <= 1'b1;
      ARB_DATA <= (SID_KIND == SIDK_PACKET) ? SID_DATA : 32'h0000_0000;
    end else if (out_state_reg == O_LO && ISO_OUT_READY && inv_pend_reg) begin
      ARB_WE <= 1'b1;
      ARB_DATA <= ~quad_reg;
    end else begin
      ARB_WE <= 1'b0;
    end
  end

  // iso receive buffer; trailers never wait for the port
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IRB_WE <= 1'b0;
      IRB_DATA <= 32'h0000_0000;
    end else if (rx_take && (RX_KIND == RXK_PAYLOAD || !rx_auto_reg)) begin
      IRB_WE <= 1'b1;
      case (RX_KIND)
        RXK_HEADER: IRB_DATA <= hdr_fixed;
        RXK_PAYLOAD: IRB_DATA <= RX_DATA;
        default: IRB_DATA <= {14'h0000, RX_SPD, 12'h000, RX_ACK};
      endcase
    end else begin
      IRB_WE <= 1'b0;
    end
  end

  // trailer checks; a set in the clearing cycle wins
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      last_ack_reg <= 4'h0;
      ack_bad_reg <= 1'b0;
      spd_bad_reg <= 1'b0;
    end else begin
      if (WSTB && ADDR == STATUS_OFF) begin
        if (WDATA[STAT_ACK_BAD_BIT]) ack_bad_reg <= 1'b0;
        if (WDATA[STAT_SPD_BAD_BIT]) spd_bad_reg <= 1'b0;
      end
      if (rx_take && RX_KIND == RXK_TRAILER) begin
        last_ack_reg <= RX_ACK;
        if (!ack_known(RX_ACK)) ack_bad_reg <= 1'b1;
        if (RX_SPD != SPD_100 && RX_SPD != SPD_200 && RX_SPD != SPD_400) begin
          spd_bad_reg <= 1'b1;
        end
      end
    end
  end

  // self-id decode: packet zero fields and the extended port map
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sid0_reg <= 32'h0000_0000;
      port_stat_reg <= '0;
    end else if (sid_take && SID_KIND == SIDK_PACKET) begin
      if (!SID_DATA[SID_EXT_BIT]) begin
        sid0_reg <= SID_DATA;
        port_stat_reg[5:0] <= {SID_DATA[3:2], SID_DATA[5:4], SID_DATA[7:6]};
      end else if (SID_DATA[SID_SEQ_LSB +: 3] <= 3'(EXT_MAX_SEQ)) begin
        for (int k = 0; k < EXT_PORTS_PER_PKT; k++) begin
          port_stat_reg[2 * (EXT_BASE_PORT + EXT_PORTS_PER_PKT *
            int'(SID_DATA[SID_SEQ_LSB +: 3]) + k) +: 2] <=
            SID_DATA[17 - 2 * k -: 2];
        end
      end
    end
  end

  always_comb begin
    parent_found = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (port_stat_reg[2 * p +: 2] == PS_PARENT) parent_found = 1'b1;
    end
  end

  assign manager_capable = sid0_reg[11] && sid0_reg[22];
  assign delay_ok = (sid0_reg[13:12] == DEL_144NS);
  assign bus_powered = sid0_reg[10];

  // transmit: word pairs into quadlets, upper half first
  assign ISO_IN_READY = !(tx_have_hi_reg && ITB_FULL);
  assign in_take = ISO_IN_VALID && ISO_IN_READY;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tx_hi_reg <= 16'h0000;
      tx_have_hi_reg <= 1'b0;
      tx_first_reg <= 1'b1;
      ITB_WE <= 1'b0;
      ITB_DATA <= 32'h0000_0000;
      ITB_HDR <= 1'b0;
    end else begin
      ITB_WE <= 1'b0;
      if (in_take && !tx_have_hi_reg && !ISO_IN_LAST) begin
        tx_hi_reg <= ISO_IN_WORD;
        tx_have_hi_reg <= 1'b1;
      end else if (in_take) begin
        // lone last word: lower half filled with zero
        ITB_WE <= 1'b1;
        ITB_DATA <= tx_have_hi_reg ? {tx_hi_reg, ISO_IN_WORD} :
                    {ISO_IN_WORD, 16'h0000};
        ITB_HDR <= tx_first_reg && !tx_auto_reg;
        tx_have_hi_reg <= 1'b0;
        tx_first_reg <= ISO_IN_LAST;
      end
    end
  end

  // register writes
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tx_auto_reg <= CTRL_TX_AUTO_RESET;
      rx_auto_reg <= CTRL_RX_AUTO_RESET;
      node_emit_reg <= 1'b0;
      root_reg <= 1'b0;
      bus_num_reg <= NODE_BUS_RESET;
      node_num_reg <= NODE_NUM_RESET;
    end else begin
      if (node_take) node_emit_reg <= 1'b0;
      if (WSTB && ADDR == CTRL_OFF) begin
        tx_auto_reg <= WDATA[CTRL_TX_AUTO_BIT];
        rx_auto_reg <= WDATA[CTRL_RX_AUTO_BIT];
        if (WDATA[CTRL_NODE_EMIT_BIT]) node_emit_reg <= 1'b1;
      end
      if (WSTB && ADDR == NODE_OFF) begin
        root_reg <= WDATA[NODE_ROOT_BIT];
        bus_num_reg <= WDATA[NODE_BUS_LSB +: 10];
        node_num_reg <= WDATA[5:0];
      end
    end
  end

  // register reads, data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !RSTB) begin
      RDATA <= 32'h0000_0000;
    end else begin
      case (ADDR)
        CTRL_OFF: RDATA <= {29'h0000_0000, node_emit_reg, rx_auto_reg,
                            tx_auto_reg};
        NODE_OFF: RDATA <= {15'h0000, root_reg, bus_num_reg, node_num_reg};
        STATUS_OFF: RDATA <= {16'h0000, parent_found, bus_powered, delay_ok,
                              manager_capable, sid0_reg[15:14] == SP_RESERVED,
                              out_state_reg != O_IDLE, spd_bad_reg,
                              ack_bad_reg, 4'h0, last_ack_reg};
        SID_OFF: RDATA <= sid0_reg;
        PORTS_LO_OFF: RDATA <= port_stat_reg[31:0];
        PORTS_HI_OFF: RDATA <= {10'h000, port_stat_reg[53:32]};
        default: RDATA <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  AST_RX_TCODE: assert property (
    rx_take && RX_KIND == RXK_HEADER && !rx_auto_reg |=>
      IRB_WE && IRB_DATA[HDR_TCODE_LSB +: 4] == TCODE_ISO)
    else $error("header tcode not forced");
  AST_RX_AUTO_STRIP: assert property (
    rx_take && RX_KIND != RXK_PAYLOAD && rx_auto_reg |=> !IRB_WE)
    else $error("auto mode stored a header or trailer");
  AST_TRAILER: assert property (
    rx_take && RX_KIND == RXK_TRAILER && !rx_auto_reg |=>
      IRB_WE && IRB_DATA[3:0] == $past(RX_ACK) &&
      IRB_DATA[TRL_SPD_LSB +: 2] == $past(RX_SPD))
    else $error("trailer content wrong");
  AST_HALVES: assert property (
    out_state_reg == O_HI && ISO_OUT_READY |=>
      out_state_reg == O_LO && ISO_OUT_WORD == $past(quad_reg[15:0]))
    else $error("lower half not after upper half");
  AST_SID_START: assert property (
    sid_take && SID_KIND == SIDK_START |=>
      ARB_WE && ARB_DATA == 32'h0000_0000 && ISO_OUT_WORD == 16'h0000)
    else $error("self-id start not zero");
  AST_SID_INVERSE: assert property (
    sid_take && SID_KIND == SIDK_PACKET ##1 ISO_OUT_READY [*2] |=>
      ARB_WE && ARB_DATA == ~$past(SID_DATA, 3) &&
      $past(ARB_DATA, 2) == $past(SID_DATA, 3))
    else $error("self-id inverse missing");
  AST_SID_MARK: assert property (
    sid_take && SID_KIND == SIDK_START ##1 ISO_OUT_READY |=>
      ISO_OUT_WORD == SID_MARK_WORD)
    else $error("self-id marker word wrong");
  AST_NODE_ID: assert property (
    node_take |=> ISO_OUT_WORD[15] == root_reg && ISO_OUT_WORD[14:0] == 15'h0000)
    else $error("node identity root word wrong");
  AST_SNOOP_SPEED: assert property (
    snp_take && SNP_IS_ACK ##1 ISO_OUT_READY [*2] |=>
      out_state_reg == O_EXTRA &&
      ISO_OUT_WORD == {14'h0000, $past(SNP_SPD, 3)})
    else $error("snoop ack speed word missing");
  AST_TX_PAIR: assert property (
    in_take && tx_have_hi_reg |=>
      ITB_WE && ITB_DATA == {$past(tx_hi_reg), $past(ISO_IN_WORD)})
    else $error("transmit quadlet mispaired");

  COV_SID_PACKET: cover property (sid_take && SID_KIND == SIDK_PACKET);
  COV_RX_HEADER: cover property (rx_take && RX_KIND == RXK_HEADER);
  COV_SNOOP_ACK: cover property (out_state_reg == O_EXTRA);
  COV_TX_HDR: cover property (ITB_WE && ITB_HDR);

endmodule // iso_bus_packet_formatter

// file: testbench/iso_far_side.sv
/*
  Far-side stream model on the iso parallel port: accepts device words
  with a stall every fourth cycle and sends frames of words on request.
  Assumes the caller enters send_frame just after a rising clock edge.
*/
`timescale 1ns/1ps
module iso_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // device to far side
  input wire logic out_valid,
  output logic out_ready,
  // far side to device
  output logic [15:0] in_word,
  output logic in_valid,
  output logic in_last,
  input wire logic in_ready
);
  logic [1:0] stall_cnt = 2'h0;

  initial begin
    out_ready = 1'b0;
    in_word = 16'h0000;
    in_valid = 1'b0;
    in_last = 1'b0;
  end

  // slow sink: one refused cycle in four
  always @(posedge clk) begin
    stall_cnt <= stall_cnt + 2'h1;
    out_ready <= !rst && (stall_cnt != 2'h3);
  end

  // words already padded with zero bytes; auto mode gets payload only
  task automatic send_frame(input logic [15:0] w[$]);
    int i;
    for (i = 0; i < w.size(); i++) begin
      in_word <= w[i];
      in_valid <= 1'b1;
      in_last <= (i == w.size() - 1);
      do @(posedge clk); while (!in_ready);
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
    // released line shows the inverse, not a stale copy
    in_word <= ~w[w.size() - 1];
    @(posedge clk);
  endtask
endmodule // iso_far_side

// file: testbench/iso_bus_packet_formatter_tb_top.sv
/*
  Self-checking bench for the isochronous packet formatter: drivers note
  expected words in queues, a watcher compares every result as it leaves.
  Assumes the far-side model in iso_far_side.sv.
*/
`timescale 1ns/1ps
module iso_bus_packet_formatter_tb_top import iso_fmt_pkg::*;;
  logic CORE_CLK = 1'b0, RESET = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000, RX_DATA = 32'h0000_0000;
  logic [31:0] SNP_DATA = 32'h0000_0000, SID_DATA = 32'h0000_0000;
  logic WSTB = 1'b0, RSTB = 1'b0, RX_VALID = 1'b0, SNP_VALID = 1'b0;
  logic SNP_IS_ACK = 1'b0, SID_VALID = 1'b0, ITB_FULL = 1'b0;
  logic [1:0] RX_KIND = 2'h0, RX_SPD = 2'h0, SNP_SPD = 2'h0, SID_KIND = 2'h0;
  logic [3:0] RX_ACK = 4'h0, SID_ACK = 4'h0;
  logic [31:0] RDATA, IRB_DATA, ARB_DATA, ITB_DATA;
  logic RX_READY, IRB_WE, SNP_READY, SID_READY, ARB_WE, ITB_WE, ITB_HDR;
  logic [15:0] ISO_OUT_WORD, ISO_IN_WORD;
  logic ISO_OUT_VALID, ISO_OUT_READY, ISO_IN_VALID, ISO_IN_LAST;
  logic ISO_IN_READY;
  logic [31:0] q_rd[$], q_msk[$], q_irb[$], q_arb[$], q_itb[$];
  logic [15:0] q_out[$], q_hdr[$], ws[$];
  logic [31:0] seed = 32'h0001_1AC9, x, h, cur_msk;
  logic [31:0] sidq[2] = '{32'h857F_8CE4, 32'h8593_5554};
  logic [3:0] ak;
  logic rd_prev = 1'b0, stall_en = 1'b0, kn;
  int cycles = 0, failures = 0, n_checks = 0;

  iso_bus_packet_formatter dut (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WSTB(WSTB), .RSTB(RSTB), .RDATA(RDATA),
    .RX_VALID(RX_VALID), .RX_KIND(RX_KIND), .RX_DATA(RX_DATA),
    .RX_SPD(RX_SPD), .RX_ACK(RX_ACK), .RX_READY(RX_READY),
    .IRB_WE(IRB_WE), .IRB_DATA(IRB_DATA), .SNP_VALID(SNP_VALID),
    .SNP_DATA(SNP_DATA), .SNP_IS_ACK(SNP_IS_ACK), .SNP_SPD(SNP_SPD),
    .SNP_READY(SNP_READY), .SID_VALID(SID_VALID), .SID_KIND(SID_KIND),
    .SID_DATA(SID_DATA), .SID_ACK(SID_ACK), .SID_READY(SID_READY),
    .ARB_WE(ARB_WE), .ARB_DATA(ARB_DATA), .ISO_OUT_WORD(ISO_OUT_WORD),
    .ISO_OUT_VALID(ISO_OUT_VALID), .ISO_OUT_READY(ISO_OUT_READY),
    .ISO_IN_WORD(ISO_IN_WORD), .ISO_IN_VALID(ISO_IN_VALID),
    .ISO_IN_LAST(ISO_IN_LAST), .ISO_IN_READY(ISO_IN_READY),
    .ITB_WE(ITB_WE), .ITB_DATA(ITB_DATA), .ITB_HDR(ITB_HDR),
    .ITB_FULL(ITB_FULL));

  iso_far_side far (.clk(CORE_CLK), .rst(RESET), .out_valid(ISO_OUT_VALID),
    .out_ready(ISO_OUT_READY), .in_word(ISO_IN_WORD),
    .in_valid(ISO_IN_VALID), .in_last(ISO_IN_LAST),
    .in_ready(ISO_IN_READY));

  always #25 CORE_CLK = ~CORE_CLK;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic pop32(ref logic [31:0] q[$], input logic [31:0] got);
    // nothing expected: any value, unknown included, must fail
    if (q.size() == 0)
      cmp32(got, (got === 32'h0000_0000) ? 32'h0000_0001 : 32'h0000_0000);
    else cmp32(got, q.pop_front());
  endtask

  task automatic pop16(ref logic [15:0] q[$], input logic [15:0] got);
    if (q.size() == 0)
      cmp16(got, (got === 16'h0000) ? 16'h0001 : 16'h0000);
    else cmp16(got, q.pop_front());
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WSTB <= 1'b1;
    @(posedge CORE_CLK);
    WSTB <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    q_rd.push_back(e & m);
    q_msk.push_back(m);
    ADDR <= a;
    RSTB <= 1'b1;
    @(posedge CORE_CLK);
    RSTB <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic rx(input logic [1:0] k, input logic [31:0] d,
                    input logic [1:0] s, input logic [3:0] a);
    {RX_KIND, RX_DATA, RX_SPD, RX_ACK} <= {k, d, s, a};
    RX_VALID <= 1'b1;
    do @(posedge CORE_CLK); while (!RX_READY);
    RX_VALID <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic snp(input logic [31:0] d, input logic ac);
    {SNP_DATA, SNP_IS_ACK, SNP_SPD} <= {d, ac, SPD_200};
    SNP_VALID <= 1'b1;
    do @(posedge CORE_CLK); while (!SNP_READY);
    SNP_VALID <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic sid(input logic [1:0] k, input logic [31:0] d);
    {SID_KIND, SID_DATA, SID_ACK} <= {k, d, ACK_COMPLETE};
    SID_VALID <= 1'b1;
    do @(posedge CORE_CLK); while (!SID_READY);
    SID_VALID <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic push_q(input logic [31:0] d);
    q_out.push_back(d[31:16]);
    q_out.push_back(d[15:0]);
  endtask

  // watcher samples settled values of the edge just reached
  always @(posedge CORE_CLK) begin
    rd_prev <= RSTB;
    ITB_FULL <= stall_en && xs() > 32'h9000_0000;
    if (rd_prev) begin
      cur_msk = q_msk.pop_front();
      pop32(q_rd, RDATA & cur_msk);
    end
    if (IRB_WE) pop32(q_irb, IRB_DATA);
    if (ARB_WE) pop32(q_arb, ARB_DATA);
    if (ITB_WE) begin
      pop32(q_itb, ITB_DATA);
      pop16(q_hdr, {15'h0000, ITB_HDR});
    end
    if (ISO_OUT_VALID && ISO_OUT_READY) pop16(q_out, ISO_OUT_WORD);
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    @(posedge CORE_CLK);
    rd(CTRL_OFF, 32'h0000_0000, 32'h0000_0003);
    rd(NODE_OFF, 32'h0000_FFFF, 32'h0001_FFFF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    push_q(32'h0000_FFFF);
    wr(CTRL_OFF, 32'h0000_0004);
    while (q_out.size() != 0) @(posedge CORE_CLK);
    x = xs();
    wr(NODE_OFF, {15'h0000, 1'b1, x[15:0]});
    push_q({16'h8000, x[15:0]});
    wr(CTRL_OFF, 32'h0000_0004);
    rd(NODE_OFF, {15'h0000, 1'b1, x[15:0]}, 32'h0001_FFFF);
    h = {16'h0008, x[23:16], 4'h3, x[27:24]};
    push_q({h[31:8], TCODE_ISO, h[3:0]});
    q_irb.push_back({h[31:8], 4'hA, h[3:0]});
    rx(RXK_HEADER, h, 2'h0, 4'h0);
    repeat (2) begin
      x = xs();
      push_q(x);
      q_irb.push_back(x);
      rx(RXK_PAYLOAD, x, 2'h0, 4'h0);
    end
    for (int a = 0; a < 16; a++) begin
      ak = 4'(a);
      kn = (ak == 4'h1) || (ak == 4'h2) || (ak >= 4'h4 && ak <= 4'h6) ||
           (ak >= 4'hD);
      wr(STATUS_OFF, 32'h0000_0300);
      q_irb.push_back({14'h0000, ak[1:0], 12'h000, ak});
      rx(RXK_TRAILER, 32'h0000_0000, ak[1:0], ak);
      rd(STATUS_OFF, {22'h0, ak[1:0] == 2'h3, !kn, 4'h0, ak},
         32'h0000_030F);
    end
    wr(CTRL_OFF, 32'h0000_0002);
    rx(RXK_HEADER, xs(), 2'h0, 4'h0);
    x = xs();
    push_q(x);
    q_irb.push_back(x);
    rx(RXK_PAYLOAD, x, 2'h0, 4'h0);
    rx(RXK_TRAILER, 32'h0000_0000, SPD_100, ACK_PENDING);
    wr(CTRL_OFF, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      x = xs();
      push_q(x);
      if (k == 1) q_out.push_back({14'h0000, 2'b01});
      snp(x, k == 1);
    end
    while (q_out.size() != 0) @(posedge CORE_CLK);
    push_q({16'h0000, 8'h00, 4'b1110, 4'h0});
    q_arb.push_back(32'h0000_0000);
    sid(SIDK_START, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      push_q(sidq[k]);
      push_q(~sidq[k]);
      q_arb.push_back(sidq[k]);
      q_arb.push_back(~sidq[k]);
      sid(SIDK_PACKET, sidq[k]);
    end
    push_q({16'h0000, 12'h000, ACK_COMPLETE});
    q_arb.push_back(32'h0000_0000);
    sid(SIDK_END, 32'h0000_0000);
    while (q_out.size() != 0) @(posedge CORE_CLK);
    rd(SID_OFF, sidq[0], 32'hFFFF_FFFF);
    rd(STATUS_OFF, 32'h0000_F000, 32'h0000_F800);
    rd(PORTS_LO_OFF, 32'h55C0_001B, 32'hFFFF_FFFF);
    rd(PORTS_HI_OFF, 32'h0000_0015, 32'hFFFF_FFFF);
    stall_en <= 1'b1;
    x = xs();
    h = xs();
    ws = '{x[31:16], x[15:0], h[31:16]};
    q_itb.push_back(x);
    q_hdr.push_back(16'h0001);
    q_itb.push_back({h[31:16], 16'h0000});
    q_hdr.push_back(16'h0000);
    far.send_frame(ws);
    wr(CTRL_OFF, 32'h0000_0001);
    ws = '{h[15:0], x[31:16]};
    q_itb.push_back({h[15:0], x[31:16]});
    q_hdr.push_back(16'h0000);
    far.send_frame(ws);
    while (q_itb.size() + q_arb.size() + q_irb.size() + q_rd.size() != 0)
      @(posedge CORE_CLK);
    complete_run();
  end
endmodule // iso_bus_packet_formatter_tb_top
